// *** verilog/asr_pkg.sv ***
// package for the async sram host port controller: constants and carriers
package asr_pkg;
  // geometry of the array
  localparam int ADDR_W = 14;      // word_index width
  localparam int DATA_W = 4;       // nibble_bus width
  // pin timing in ns, as printed for the slowest grade
  localparam int CLK_PERIOD_NS = 5;     // 200 mhz reference clock
  localparam int T_ACCESS_NS   = 85;    // address / select access time
  localparam int T_WPULSE_NS   = 45;    // write pulse width
  localparam int T_DSETUP_NS   = 35;    // data valid to end of write
  localparam int T_DHOLD_NS    = 5;     // data hold after end of write
  localparam int T_HIZ_NS      = 40;    // deselect to outputs floating
  // least times round up to whole cycles
  localparam int ACC_CYC  = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC   = (T_WPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DH_CYC   = (T_DHOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HIZ_CYC  = (T_HIZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W    = 6;     // wide enough for every count above
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 6'h01;

  // request from the user side
  typedef struct packed {
    logic              wr;     // 1 = write, 0 = read
    logic [ADDR_W-1:0] addr;   // word index
    logic [DATA_W-1:0] wdata;  // write nibble
  } asr_req_t;

  // controller states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_WAIT,
    ST_WR_PULSE,
    ST_WR_HOLD,
    ST_RECOVER
  } asr_state_t;

  // state of the controller, apart from the read pin sync flops
  typedef struct packed {
    asr_state_t        st;
    logic [CNT_W-1:0]  cnt;
    logic              sel_n;
    logic              store_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic              doe;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
    logic              ready;
  } asr_regs_t;
endpackage

// *** verilog/asr_host.sv ***
// host controller that runs one async sram word port from a clocked side
//
// How it works
// RQ1 - 16k words of 4 bits, 14-bit index
// RQ2 - select high puts device in standby
// RQ3 - reads keep store strobe high
// RQ4 - select held low for whole read
// RQ5 - address valid before select falls; code loads address and lowers select on the same clock edge
// RQ6 - address changes only when select high
// RQ7 - write happens while both strobes low
// RQ8 - write ends at first strobe rising
// RQ9 - select falls with strobe: outputs stay off
// RQ10 - strobe low floats device read drivers
// RQ11 - strobe high again re-enables device drivers
// RQ12 - read data follows address asynchronously
// RQ13 - hold write data past end; no contention
// RQ14 - device is clockless, purely level driven
module asr_host (
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_sys_rst,
  input  wire logic                          i_req_valid,
  input  wire asr_pkg::asr_req_t             i_req,
  output logic                               o_req_ready,
  output logic [asr_pkg::DATA_W-1:0]         o_rdata,
  output logic                               o_rvalid,
  output logic                               o_sel_n,
  output logic                               o_store_n,
  output logic [asr_pkg::ADDR_W-1:0]         o_word_index,
  output logic [asr_pkg::DATA_W-1:0]         o_nibble_bus_o,
  output logic                               o_nibble_bus_oe,
  input  wire logic [asr_pkg::DATA_W-1:0]    i_nibble_bus_i
);
  asr_pkg::asr_regs_t r_reg;               // registered state except the pin sync flops
  asr_pkg::asr_regs_t r_next;              // its next value
  logic [asr_pkg::DATA_W-1:0] rd_s1_reg;   // pin sync stage one
  logic [asr_pkg::DATA_W-1:0] rd_s2_reg;   // pin sync stage two
  logic [asr_pkg::DATA_W-1:0] rd_s3_reg;   // pin sync stage three

  // every assertion below runs on the reference clock, off in reset
  default clocking cb_ref @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);

  // load a down counter with a cycle count
  function automatic logic [asr_pkg::CNT_W-1:0] cyc(input int n);
    cyc = asr_pkg::CNT_W'(n);
  endfunction

  // read pins pass three flops; data counts once stages two and three agree
  always_ff @(posedge i_ref_clk)
  begin
    rd_s1_reg <= i_nibble_bus_i;
    rd_s2_reg <= rd_s1_reg;
    rd_s3_reg <= rd_s2_reg;
  end

  // next-state logic
  always_comb
  begin
    r_next = r_reg;
    r_next.rvalid = 1'b0;
    if (r_reg.cnt != asr_pkg::CNT_ZERO)
    begin
      r_next.cnt = r_reg.cnt - asr_pkg::CNT_ONE;
    end
    case (r_reg.st)
      // deselected, pins quiet
      asr_pkg::ST_IDLE:
      begin
        // RQ2 standby while idle
        r_next.sel_n   = 1'b1;
        r_next.store_n = 1'b1;
        r_next.ready   = 1'b1;
        if (i_req_valid && r_reg.ready)
        begin
          r_next.ready = 1'b0;
          // RQ5 RQ6 address set while deselected
          r_next.addr  = i_req.addr;
          r_next.sel_n = 1'b0;
          if (i_req.wr)
          begin
            // RQ9 strobe falls with select, device never drives
            r_next.store_n = 1'b0;
            r_next.dout    = i_req.wdata;
            r_next.doe     = 1'b1;
            r_next.cnt     = cyc(asr_pkg::WP_CYC);
            r_next.st      = asr_pkg::ST_WR_PULSE;
          end
          else
          begin
            // RQ3 strobe high for reads; wait access plus sync delay
            r_next.cnt = cyc(asr_pkg::ACC_CYC + 3);
            r_next.st  = asr_pkg::ST_RD_WAIT;
          end
        end
      end
      // read: select stays low until data is settled and sampled
      asr_pkg::ST_RD_WAIT:
      begin
        // RQ4 select held low through the access
        // RQ12 sample only once async data has settled and stages agree
        if (r_reg.cnt == asr_pkg::CNT_ZERO && rd_s2_reg == rd_s3_reg)
        begin
          r_next.rdata  = rd_s3_reg;
          r_next.rvalid = 1'b1;
          r_next.sel_n  = 1'b1;
          r_next.cnt    = cyc(asr_pkg::HIZ_CYC);
          r_next.st     = asr_pkg::ST_RECOVER;
        end
      end
      // write pulse: both strobes low, data already on the bus
      asr_pkg::ST_WR_PULSE:
      begin
        if (r_reg.cnt == asr_pkg::CNT_ZERO)
        begin
          // RQ8 select rise ends the write; strobe and data stay
          // a strobe-ended write would wake the device outputs while
          // our data is still driven, so select closes it instead
          r_next.sel_n = 1'b1;
          r_next.cnt   = cyc(asr_pkg::DH_CYC);
          r_next.st    = asr_pkg::ST_WR_HOLD;
        end
      end
      // data hold after end of write
      asr_pkg::ST_WR_HOLD:
      begin
        // RQ13 release bus and strobe together; device is deselected
        if (r_reg.cnt == asr_pkg::CNT_ZERO)
        begin
          r_next.doe     = 1'b0;
          r_next.store_n = 1'b1;
          r_next.cnt     = cyc(asr_pkg::HIZ_CYC);
          r_next.st      = asr_pkg::ST_RECOVER;
        end
      end
      // let device outputs float before the next cycle
      asr_pkg::ST_RECOVER:
      begin
        if (r_reg.cnt == asr_pkg::CNT_ZERO)
        begin
          r_next.ready = 1'b1;
          r_next.st    = asr_pkg::ST_IDLE;
        end
      end
      default:
      begin
        r_next.st = asr_pkg::ST_IDLE;
      end
    endcase
  end

  // state register with synchronous reset
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      r_reg         <= '0;
      r_reg.st      <= asr_pkg::ST_IDLE;
      r_reg.sel_n   <= 1'b1;
      r_reg.store_n <= 1'b1;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // outputs straight from flops
  assign o_req_ready     = r_reg.ready;
  assign o_rdata         = r_reg.rdata;
  assign o_rvalid        = r_reg.rvalid;
  assign o_sel_n         = r_reg.sel_n;
  assign o_store_n       = r_reg.store_n;
  assign o_word_index    = r_reg.addr;
  assign o_nibble_bus_o  = r_reg.dout;
  assign o_nibble_bus_oe = r_reg.doe;

  // write framing in steps: open together, overlap, select closes
  sequence s_write_open;
    $fell(o_store_n) && $fell(o_sel_n) && o_nibble_bus_oe;
  endsequence
  sequence s_write_overlap;
    (!o_store_n && !o_sel_n && o_nibble_bus_oe) [*8];
  endsequence
  sequence s_write_close;
    o_sel_n && !o_store_n && o_nibble_bus_oe;
  endsequence

  // RQ6 address stable while both strobes low
  a_addr_stable_low: assert property ( // RQ6
    (!o_sel_n && !$past(o_sel_n) && !$past(o_store_n))
    |-> $stable(o_word_index))
    else $error("address moved while selected");
  // RQ5 address only moves out of a deselected cycle
  a_addr_moves_idle: assert property ( // RQ5
    $changed(o_word_index) |-> $past(o_sel_n))
    else $error("address moved while device selected");
  // RQ3 read keeps store high
  a_read_strobe_high: assert property ( // RQ3
    (r_reg.st == asr_pkg::ST_RD_WAIT) |-> o_store_n)
    else $error("store strobe low during read");
  // RQ13 host drives only while the strobe keeps device off
  a_no_contention: assert property ( // RQ13
    (o_nibble_bus_oe && !o_sel_n) |-> !o_store_n)
    else $error("bus driven while device outputs enabled");
  // RQ13 data held two cycles past write end; checked in the cycle select rises
  a_data_hold: assert property ( // RQ13
    ($rose(o_sel_n) && !o_store_n)
    |-> o_nibble_bus_oe && $stable(o_nibble_bus_o))
    else $error("write data dropped at write end");
  // RQ9 select and strobe fall together for writes
  a_write_start: assert property ( // RQ9
    $fell(o_store_n) |-> $fell(o_sel_n))
    else $error("strobe fell while already selected");
  // RQ4 select low for the first 8 cycles of a read, then rvalid
  a_read_select: assert property ( // RQ4
    ($fell(o_sel_n) && o_store_n) |-> !o_sel_n [*8] ##[1:40] o_rvalid)
    else $error("read select too short or no data");
  // RQ4 read data taken as select is released
  a_read_release: assert property ( // RQ4
    o_rvalid |-> $rose(o_sel_n) ##1 !o_rvalid)
    else $error("read data not paired with select release");
  // RQ7 write pulse width
  a_write_width: assert property ( // RQ7
    $fell(o_store_n) |-> (!o_store_n && !o_sel_n) [*8])
    else $error("write pulse too short");
  // RQ8 select ends the write, data still on the bus
  a_write_frame: assert property ( // RQ8
    s_write_open |-> s_write_overlap ##[1:4] s_write_close)
    else $error("write not closed by select");
  // RQ2 idle keeps device in standby
  a_idle_standby: assert property ( // RQ2
    o_req_ready |-> o_sel_n && !o_nibble_bus_oe)
    else $error("selected while idle");
endmodule

// *** verification/asr_sram_model.sv ***
// behavioural model of the async 16k x 4 word memory behind the host port
module asr_sram_model #(
  parameter int ACC_NS = 85             // access delay, slow grade by default
) (
  input  wire logic                       i_sel_n,
  input  wire logic                       i_store_n,
  input  wire logic [asr_pkg::ADDR_W-1:0] i_word_index,
  input  wire logic [asr_pkg::DATA_W-1:0] i_bus_in,
  output logic [asr_pkg::DATA_W-1:0]      o_bus_out,
  output logic                            o_bus_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [asr_pkg::DATA_W-1:0] mem [0:16383];
  // drive only while selected and not storing
  assign o_bus_oe = !i_sel_n && i_store_n;
  // data trails the address, no clock involved
  assign #(ACC_NS) o_bus_out = mem[i_word_index];
  // overlap of both lows stores; level the host holds last wins
  always @*
    if (!i_sel_n && !i_store_n)
      mem[i_word_index] = i_bus_in;
endmodule

// *** verification/asr_host_bench.sv ***
// self-checking bench for the async sram host controller
module asr_host_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, valid, rvalid, sel_n, store_n, ready, oe, m_oe;
  asr_pkg::asr_req_t rq;
  logic [3:0] rdata, hout, m_out, bus, last_q;
  logic [13:0] widx, alist [8];
  logic [3:0] shadow [0:16383];
  logic [3:0] exp_q [$];
  int errors, checks_done, cyc;
  // released bus shows the inverse of its last driven level
  assign bus = oe ? hout : (m_oe ? m_out : ~last_q);
  always @(posedge clk)
    if (oe || m_oe)
      last_q <= bus;
  asr_host i_asr_host (.i_ref_clk(clk), .i_sys_rst(rst), .i_req_valid(valid),
    .i_req(rq), .o_req_ready(ready), .o_rdata(rdata), .o_rvalid(rvalid),
    .o_sel_n(sel_n), .o_store_n(store_n), .o_word_index(widx),
    .o_nibble_bus_o(hout), .o_nibble_bus_oe(oe), .i_nibble_bus_i(bus));
  asr_sram_model i_asr_sram_model (.i_sel_n(sel_n), .i_store_n(store_n),
    .i_word_index(widx), .i_bus_in(bus), .o_bus_out(m_out), .o_bus_oe(m_oe));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // compare one value, count it
  task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one request, taken at the rising edge while ready is high
  task automatic issue(input logic w, input logic [13:0] a,
                       input logic [3:0] d);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    rq.wr = w;
    rq.addr = a;
    rq.wdata = d;
    valid = 1'b1;
    if (w)
      shadow[a] = d;
    else
      exp_q.push_back(shadow[a]);
    @(negedge clk);
    valid = 1'b0;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // read results leave the queue in issue order
  always @(negedge clk)
    if (rvalid === 1'b1)
    begin
      if (exp_q.size() == 0)
        cmp(rdata, 4'hx);
      else
        cmp(rdata, exp_q.pop_front());
    end
  // host must never fight the device outputs
  always @(negedge clk)
    if (!rst)
      cmp({3'h0, oe & m_oe}, 4'h0);
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      errors++;
      test_done();
    end
  end
  initial
  begin
    errors = 0;
    checks_done = 0;
    cyc = 0;
    rst = 1'b1;
    valid = 1'b0;
    rq = '0;
    last_q = 4'h0;
    void'($urandom(93));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    // boundary and random words, written then read back
    alist[0] = 14'h0000;
    alist[1] = 14'h3fff;
    for (int i = 2; i < 8; i++)
      alist[i] = 14'($urandom_range(16383));
    for (int i = 0; i < 8; i++)
      issue(1'b1, alist[i], 4'($urandom_range(15)));
    for (int i = 0; i < 8; i++)
      issue(1'b0, alist[i], 4'h0);
    $display("test word round trip done");
    // overwrite, then a request while busy must be ignored
    issue(1'b1, 14'h1555, 4'h5);
    issue(1'b1, 14'h1555, 4'ha);
    // let one edge pass so valid is not lowered and raised at once
    @(negedge clk);
    rq.wr = 1'b1;
    rq.addr = 14'h1555;
    rq.wdata = 4'h3;
    valid = 1'b1;
    @(negedge clk);
    valid = 1'b0;
    issue(1'b0, 14'h1555, 4'h0);
    issue(1'b0, 14'h3fff, 4'h0);
    $display("test overwrite and refusal done");
    repeat (60) @(negedge clk);
    cmp(4'(exp_q.size()), 4'h0);
    test_done();
  end
endmodule
